// [hw/adc_timing_regs.svh]
// Register map, field positions, reset values and timing counts for the timing control block
`ifndef ADC_TIMING_REGS_SVH
`define ADC_TIMING_REGS_SVH

// ==========================================================
// Register map
`define TIMING_CONTROL_OFFSET 8'h00
`define STATUS_OFFSET         8'h01
`define TIMING_CONTROL_RESET  8'h00

// ==========================================================
// Field positions
`define JUSTIFY_BIT           7
`define UNUSED_BIT            6
`define ACQ_MSB               5
`define ACQ_LSB               3
`define CLK_MSB               2
`define CLK_LSB               0
`define WRITE_MASK            8'hbf

// ==========================================================
// Timing: instruction cycle is four system clocks
`define INSTR_CYCLE_CLOCKS    4

`endif

// [hw/adc_timing_pkg.sv]
// Types shared by the timing control block
package adc_timing_pkg;
  typedef enum logic [1:0] {
    SRC_SYSTEM,
    SRC_RC_WAIT,
    SRC_RC_RUN
  } clock_source_type;
endpackage

// [hw/acq_time_decode.sv]
// Acquisition time field decoder
module acq_time_decode (
  // Field in
  input  wire logic [2:0] acq_select,
  // Periods out
  output wire logic [4:0] acq_periods
);
  // (R2) Acquisition period table
  assign acq_periods = (acq_select == 3'h7) ? 5'h14 :
                       (acq_select == 3'h6) ? 5'h10 :
                       (acq_select == 3'h5) ? 5'h0c :
                       (acq_select == 3'h4) ? 5'h08 :
                       (acq_select == 3'h3) ? 5'h06 :
                       (acq_select == 3'h2) ? 5'h04 :
                       (acq_select == 3'h1) ? 5'h02 : 5'h00;
endmodule

// [hw/conv_clock_divider.sv]
// System clock divider producing conversion clock enable pulses
module conv_clock_divider #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Control
  input  wire logic [2:0] clock_select,
  // Enable out
  output logic            tick
);
  logic [WIDTH-1:0] count_q;
  wire  [WIDTH-1:0] limit;

  // Divide by 64 needs six counter bits
  if (WIDTH < 6)
  begin : g_width_check
    $error("divider width too small for divide by 64");
  end

  // (R3) Divide ratio minus one
  assign limit = (clock_select == 3'h0) ? WIDTH'(1)  :
                 (clock_select == 3'h1) ? WIDTH'(7)  :
                 (clock_select == 3'h2) ? WIDTH'(31) :
                 (clock_select == 3'h4) ? WIDTH'(3)  :
                 (clock_select == 3'h5) ? WIDTH'(15) : WIDTH'(63);

  always_ff @(posedge core_clk)
  begin
    if (rst || count_q >= limit)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_q + WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    tick <= !rst && (count_q >= limit);
  end
endmodule

// [hw/adc_timing_config.sv]
// Converter timing control register with clock source selection
// What this block does
// (R1) Justify bit selects right or left result
// (R2) Acquisition field decodes to conversion clock periods
// (R3) Clock field selects system clock divide
// (R4) Codes 011 and 111 select RC clock
// (R5) RC clock starts one instruction cycle late
// (R6) Reset clears fields; bit 6 reads zero
`include "adc_timing_regs.svh"
module adc_timing_config (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // Converter side
  input  wire logic        rc_clock_pin,
  input  wire logic [9:0]  raw_result,
  output logic      [15:0] justified_result,
  output logic      [4:0]  acq_periods_out,
  output logic             conv_clock_tick,
  output logic             rc_selected
);
  // ==========================================================
  // Register
  logic [7:0] control_q;
  logic [7:0] control_d;
  wire        write_hit;
  wire        rc_code;
  wire  [4:0] acq_periods;
  wire        div_tick;

  assign write_hit = reg_write && (reg_addr == `TIMING_CONTROL_OFFSET);
  // (R6) Unused bit never stored
  assign control_d = reg_wdata & `WRITE_MASK;

  always_ff @(posedge core_clk)
  begin
    // (R6) Reset clears fields
    if (rst)
    begin
      control_q <= `TIMING_CONTROL_RESET;
    end
    else if (write_hit)
    begin
      control_q <= control_d;
    end
  end

  // ==========================================================
  // Read port
  adc_timing_pkg::clock_source_type source_q;
  wire [7:0] read_mux;
  assign read_mux = (reg_addr == `TIMING_CONTROL_OFFSET) ? control_q :
                    (reg_addr == `STATUS_OFFSET) ? {6'h00, source_q == adc_timing_pkg::SRC_RC_RUN,
                                                    source_q == adc_timing_pkg::SRC_RC_WAIT} :
                    8'h00;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= reg_read ? read_mux : 8'h00;
    end
  end

  // ==========================================================
  // Acquisition time
  acq_time_decode u_acq (
    .acq_select  (control_q[`ACQ_MSB:`ACQ_LSB]),
    .acq_periods (acq_periods)
  );

  always_ff @(posedge core_clk)
  begin
    acq_periods_out <= rst ? 5'h00 : acq_periods;
  end

  // ==========================================================
  // Result justification
  // (R1) Justify by select bit
  wire [15:0] justified;
  assign justified = control_q[`JUSTIFY_BIT] ? {6'h00, raw_result} : {raw_result, 6'h00};

  always_ff @(posedge core_clk)
  begin
    justified_result <= rst ? 16'h0000 : justified;
  end

  // ==========================================================
  // Conversion clock source
  conv_clock_divider #(.WIDTH(6)) u_div (
    .core_clk     (core_clk),
    .rst          (rst),
    .clock_select (control_q[`CLK_MSB:`CLK_LSB]),
    .tick         (div_tick)
  );

  // (R4) RC codes
  assign rc_code = (control_q[1:0] == 2'h3);

  // RC oscillator pin is asynchronous, two stages before use
  logic rc_sync1_q;
  logic rc_sync2_q;
  logic rc_prev_q;
  wire  rc_rise;
  always_ff @(posedge core_clk)
  begin
    rc_sync1_q <= rst ? 1'b0 : rc_clock_pin;
    rc_sync2_q <= rst ? 1'b0 : rc_sync1_q;
    rc_prev_q  <= rst ? 1'b0 : rc_sync2_q;
  end
  assign rc_rise = rc_sync2_q && !rc_prev_q;

  // Start delay lets a sleep execute before conversion begins
  logic [2:0] wait_q;
  adc_timing_pkg::clock_source_type source_d;
  always_comb
  begin
    source_d = source_q;
    unique case (source_q)
      adc_timing_pkg::SRC_SYSTEM:  if (rc_code) source_d = adc_timing_pkg::SRC_RC_WAIT;
      adc_timing_pkg::SRC_RC_WAIT:
        if (!rc_code) source_d = adc_timing_pkg::SRC_SYSTEM;
        else if (wait_q == 3'(`INSTR_CYCLE_CLOCKS - 1)) source_d = adc_timing_pkg::SRC_RC_RUN;
      adc_timing_pkg::SRC_RC_RUN:  if (!rc_code) source_d = adc_timing_pkg::SRC_SYSTEM;
      default:                     source_d = adc_timing_pkg::SRC_SYSTEM;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      source_q <= adc_timing_pkg::SRC_SYSTEM;
      wait_q   <= 3'h0;
    end
    else
    begin
      source_q <= source_d;
      // (R5) Count instruction cycle
      wait_q   <= (source_q == adc_timing_pkg::SRC_RC_WAIT) ? wait_q + 3'h1 : 3'h0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      conv_clock_tick <= 1'b0;
      rc_selected     <= 1'b0;
    end
    else
    begin
      // (R4) Clock source mux
      conv_clock_tick <= rc_code ? (source_q == adc_timing_pkg::SRC_RC_RUN) && rc_rise
                                 : div_tick;
      rc_selected     <= rc_code;
    end
  end

  // ==========================================================
  // Checks
  property p_unused_zero;
    @(posedge core_clk) disable iff (rst) reg_read |=> (reg_rdata[`UNUSED_BIT] == 1'b0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("bit 6 read nonzero"); // (R6)

  property p_reset_clears;
    @(posedge core_clk) rst |=> (control_q == 8'h00);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear"); // (R6)

  property p_justify;
    @(posedge core_clk) disable iff (rst)
      1'b1 |=> (justified_result == ($past(control_q[7]) ? {6'h00, $past(raw_result)}
                                                         : {$past(raw_result), 6'h00}));
  endproperty
  a_justify: assert property (p_justify) else $error("wrong justification"); // (R1)

  property p_acq;
    @(posedge core_clk) disable iff (rst)
      (control_q[5:3] == 3'h7) && $stable(control_q) |=> (acq_periods_out == 5'h14);
  endproperty
  a_acq: assert property (p_acq) else $error("acquisition decode wrong"); // (R2)

  property p_rc_delay;
    @(posedge core_clk) disable iff (rst)
      $rose(rc_code) |=> !conv_clock_tick[*4];
  endproperty
  a_rc_delay: assert property (p_rc_delay) else $error("RC clock started early"); // (R5)

  property p_rc_select;
    @(posedge core_clk) disable iff (rst)
      rc_code |=> rc_selected;
  endproperty
  a_rc_select: assert property (p_rc_select) else $error("RC source not flagged"); // (R4)

  property p_div2;
    @(posedge core_clk) disable iff (rst)
      (control_q[2:0] == 3'h0) && (control_q == $past(control_q)) &&
      (control_q == $past(control_q, 2)) && conv_clock_tick |=> !conv_clock_tick;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by 2 wrong"); // (R3)

  // (R6) Write lands masked
  property p_write_lands;
    @(posedge core_clk) disable iff (rst)
      write_hit |=> (control_q == ($past(reg_wdata) & `WRITE_MASK));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("control write lost"); // (R6)

  // (R6) Stray write ignored
  property p_stray_write;
    @(posedge core_clk) disable iff (rst)
      reg_write && (reg_addr != `TIMING_CONTROL_OFFSET) |=> $stable(control_q);
  endproperty
  a_stray_write: assert property (p_stray_write) else $error("stray write landed"); // (R6)

  // (R6) Idle read data
  property p_rdata_idle;
    @(posedge core_clk) disable iff (rst)
      !reg_read |=> (reg_rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle"); // (R6)

  // (R6) Control read back
  property p_read_control;
    @(posedge core_clk) disable iff (rst)
      reg_read && (reg_addr == `TIMING_CONTROL_OFFSET) |=> (reg_rdata == $past(control_q));
  endproperty
  a_read_control: assert property (p_read_control) else $error("control read wrong"); // (R6)

  // (R2) Zero periods
  property p_acq_zero;
    @(posedge core_clk) disable iff (rst)
      (control_q[5:3] == 3'h0) && $stable(control_q) |=> (acq_periods_out == 5'h00);
  endproperty
  a_acq_zero: assert property (p_acq_zero) else $error("acquisition zero wrong"); // (R2)

  // (R2) Six periods
  property p_acq_six;
    @(posedge core_clk) disable iff (rst)
      (control_q[5:3] == 3'h3) && $stable(control_q) |=> (acq_periods_out == 5'h06);
  endproperty
  a_acq_six: assert property (p_acq_six) else $error("acquisition six wrong"); // (R2)

  // (R2) Twelve periods
  property p_acq_twelve;
    @(posedge core_clk) disable iff (rst)
      (control_q[5:3] == 3'h5) && $stable(control_q) |=> (acq_periods_out == 5'h0c);
  endproperty
  a_acq_twelve: assert property (p_acq_twelve) else $error("acquisition twelve wrong"); // (R2)

  // (R4) No tick before run
  property p_rc_no_tick;
    @(posedge core_clk) disable iff (rst)
      rc_code && (source_q != adc_timing_pkg::SRC_RC_RUN) |=> !conv_clock_tick;
  endproperty
  a_rc_no_tick: assert property (p_rc_no_tick) else $error("tick before RC run"); // (R4)

  // (R5) Wait ends in run
  property p_wait_to_run;
    @(posedge core_clk) disable iff (rst)
      (source_q == adc_timing_pkg::SRC_RC_WAIT) && (wait_q == 3'h3) && rc_code
      |=> (source_q == adc_timing_pkg::SRC_RC_RUN);
  endproperty
  a_wait_to_run: assert property (p_wait_to_run) else $error("RC run not reached"); // (R5)

  // (R5) Never skip wait
  property p_no_skip_wait;
    @(posedge core_clk) disable iff (rst)
      (source_q == adc_timing_pkg::SRC_SYSTEM) |=> (source_q != adc_timing_pkg::SRC_RC_RUN);
  endproperty
  a_no_skip_wait: assert property (p_no_skip_wait) else $error("RC wait skipped"); // (R5)

  // (R5) Status bits exclusive
  property p_status_excl;
    @(posedge core_clk) disable iff (rst)
      reg_read && (reg_addr == `STATUS_OFFSET)
      |=> (reg_rdata[7:2] == 6'h00) && !(reg_rdata[1] && reg_rdata[0]);
  endproperty
  a_status_excl: assert property (p_status_excl) else $error("status bits wrong"); // (R5)

  // (R4) Leaving RC is immediate
  property p_rc_release;
    @(posedge core_clk) disable iff (rst)
      !rc_code |=> (source_q == adc_timing_pkg::SRC_SYSTEM);
  endproperty
  a_rc_release: assert property (p_rc_release) else $error("RC source held"); // (R4)

  // (R3) Divider drives tick
  property p_div_path;
    @(posedge core_clk) disable iff (rst)
      !rc_code |=> (conv_clock_tick == $past(div_tick));
  endproperty
  a_div_path: assert property (p_div_path) else $error("divider tick lost"); // (R3)

  // (R6) Reset clears outputs
  property p_reset_outputs;
    @(posedge core_clk)
      rst |=> !conv_clock_tick && !rc_selected && (reg_rdata == 8'h00) &&
              (acq_periods_out == 5'h00) && (justified_result == 16'h0000);
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not cleared"); // (R6)
endmodule

// [verification/test_adc_timing_config.sv]
// Self-checking bench for the converter timing control block
module test_adc_timing_config;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        rc_clock_pin = 1'b0;
  logic [9:0]  raw_result = 10'h000;
  logic [7:0]  reg_rdata;
  logic [15:0] justified_result;
  logic [4:0]  acq_periods_out;
  logic        conv_clock_tick;
  logic        rc_selected;
  logic        rd_d = 1'b0;
  logic [15:0] q [$];
  logic [7:0]  d;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          c;
  int          acq_tbl [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int          div_tbl [8] = '{2, 8, 32, 0, 4, 16, 64, 0};

  adc_timing_config dut (
    .core_clk         (core_clk),
    .rst              (rst),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_write        (reg_write),
    .reg_read         (reg_read),
    .reg_rdata        (reg_rdata),
    .rc_clock_pin     (rc_clock_pin),
    .raw_result       (raw_result),
    .justified_result (justified_result),
    .acq_periods_out  (acq_periods_out),
    .conv_clock_tick  (conv_clock_tick),
    .rc_selected      (rc_selected)
  );

  initial
  begin
    forever #50 core_clk = ~core_clk;
  end

  // RC oscillator runs free, unrelated to the bus traffic
  always @(posedge core_clk)
    rc_clock_pin <= ~rc_clock_pin;

  // ==========================================================
  // Tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    q.push_back(e);
    @(posedge core_clk);
    reg_read <= 1'b0;
  endtask

  // Bounded so a dead divider cannot hang the run
  task automatic wait_tick(output int n);
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (conv_clock_tick !== 1'b1 && n < 200);
  endtask

  // ==========================================================
  // Read data monitor and timeout
  always @(posedge core_clk)
    rd_d <= reg_read;

  always @(negedge core_clk)
    if (rd_d === 1'b1 && q.size() > 0)
      check({8'h00, reg_rdata}, q.pop_front());

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h3dc5));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'h0000);
    rd(8'h55, 16'h0000);
    // bit 6 dropped, stray address ignored
    repeat (4)
    begin
      d = 8'($urandom);
      wr(8'h00, d);
      wr(8'h02, ~d);
      rd(8'h00, {8'h00, d & 8'hbf});
    end
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h00, 16'h0000);
    for (int j = 0; j < 2; j++)
    begin
      wr(8'h00, j ? 8'h80 : 8'h00);
      repeat (3)
      begin
        @(posedge core_clk);
        raw_result <= 10'($urandom);
        @(posedge core_clk);
        @(negedge core_clk);
        check(justified_result, j ? {6'h00, raw_result} : {raw_result, 6'h00});
      end
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h00, 8'(k << 3));
      repeat (3) @(negedge core_clk);
      check(16'(acq_periods_out), 16'(acq_tbl[k]));
    end
    for (int k = 0; k < 8; k++)
      if (div_tbl[k] != 0)
      begin
        wr(8'h00, 8'(k));
        wait_tick(c);
        wait_tick(c);
        wait_tick(c);
        check(16'(c), 16'(div_tbl[k]));
        check(16'(rc_selected), 16'h0000);
      end
    // delay reapplied on each return to RC
    for (int k = 3; k < 8; k += 4)
    begin
      wr(8'h00, 8'h00);
      wr(8'h00, 8'(k));
      rd(8'h01, 16'h0001);
      wait_tick(c);
      rd(8'h01, 16'h0002);
      check(16'(rc_selected), 16'h0001);
      wait_tick(c);
      wait_tick(c);
      check(16'(c), 16'h0002);
    end
    end_sim();
  end
endmodule
